// >>> rtl/mcp_mem.sv
// Management memory: single port, read-before-write, registered read data.
// Assumes the controller holds addr steady for a cycle before using rdata.
`timescale 1ns/1ns
`default_nettype none

module mcp_mem #(
	parameter int unsigned AW = 8,
	parameter int unsigned DW = 8
)(
	input  wire logic clk,
	mcp_mem_if.mem    port
);
	logic [DW-1:0] store_q [2**AW];
	logic [DW-1:0] rdata_q;

	// ==========================================================
	// Storage and read register
	always_ff @(posedge clk)
	begin
		if (port.we)
		begin
			store_q[port.addr] <= port.wdata;
		end
		rdata_q <= store_q[port.addr];
	end

	assign port.rdata = rdata_q;

endmodule : mcp_mem

`default_nettype wire

// >>> rtl/mcp_mem_if.sv
// Carrier between the control logic and its management memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface mcp_mem_if #(
	parameter int unsigned AW = 8,
	parameter int unsigned DW = 8
);
	logic          we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	// ==========================================================
	// Ends
	modport ctl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);

endinterface : mcp_mem_if

`default_nettype wire

// >>> rtl/mcp_pkg.sv
// Constants, offsets and state types shared by the module control pin logic.
// Assumes a 50 MHz system clock and a 256-byte management memory.
package mcp_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned RESET_MIN_NS   = 2000;   // Shortest accepted reset pulse
	localparam int unsigned RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Memory map layout
	localparam int unsigned MEM_AW          = 8;
	localparam int unsigned MEM_DW          = 8;
	localparam logic [7:0]  OFS_STATUS      = 8'h02;
	localparam logic [7:0]  OFS_FLAGS       = 8'h03;
	localparam logic [7:0]  OFS_POWER       = 8'h5D;
	localparam int unsigned STATUS_PEND_BIT = 0;    // data_pending_flag
	localparam int unsigned FLAG_RESET_BIT  = 0;    // Reset completed
	localparam int unsigned FLAG_FAULT_BIT  = 1;    // Fault seen
	localparam int unsigned POWER_LP_BIT    = 0;    // Software low power
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [7:0]  WALK_LAST       = 8'hFF;

	// ==========================================================
	// Serial bus
	localparam logic [6:0]  DEV_ADDR_DEF    = 7'h50;
	localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
	localparam logic [3:0]  LAST_DATA_BIT   = 4'h7;
	localparam int unsigned SYNC_W          = 7;

	// ==========================================================
	// State types
	typedef enum logic
	{
		MCP_RS_CLEAR = 1'b0,
		MCP_RS_READY = 1'b1
	} mcp_rs_t;

	typedef enum logic [2:0]
	{
		MCP_TW_IDLE = 3'b000,
		MCP_TW_ADDR = 3'b001,
		MCP_TW_WRA  = 3'b011,
		MCP_TW_WR   = 3'b010,
		MCP_TW_RD   = 3'b101
	} mcp_tw_t;

endpackage : mcp_pkg

// >>> rtl/mcp_top.sv
// Low-speed control pins of a pluggable module: select, reset, interrupt,
// presence, low power and the two-wire management bus.
// Assumes the board pulls SDA and the interrupt line up; link_scl is the bus clock.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Bus transfers are answered only while module_select_n is held low.
// - Host reads and writes the management memory over the serial bus.
// - A long enough reset pulse clears every memory setting to default.
// - Reset end clears data_pending_flag and pulls interrupt_n low.
// - Power-up posts the same completion interrupt without a reset pulse.
// - low_power_request limits the module's maximum power.
// - Presence line is driven to ground while the module is fitted.
// - interrupt_n goes low on a fault outside the reset hold and default walk, or on reset completion.
// - interrupt_n is only pulled low or released, never driven high.
module mcp_top #(
	parameter logic [6:0]  DEV_ADDR      = mcp_pkg::DEV_ADDR_DEF,
	parameter int unsigned RESET_MIN_CYC = mcp_pkg::RESET_MIN_CYC
)(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic link_scl,
	input  wire logic sda_i,
	output var  logic sda_o,
	output var  logic sda_oe_n,
	input  wire logic module_select_n,
	input  wire logic module_reset_n,
	input  wire logic low_power_request,
	input  wire logic fault_in,
	output var  logic interrupt_o,
	output var  logic interrupt_oe_n,
	output var  logic module_present_o,
	output var  logic module_present_oe_n,
	output var  logic power_limit,
	output var  logic reset_busy
);
	localparam int unsigned CW = $clog2(RESET_MIN_CYC + 1);

	// ==========================================================
	// Parameter check
	if (RESET_MIN_CYC < 1 || RESET_MIN_CYC > 65535)
	begin : g_bad_min
		$error("RESET_MIN_CYC out of range");
	end

	// ==========================================================
	// Link domain: capture each bit on the rising bus clock
	logic rst_l1_q;
	logic rst_l2_q;
	logic bit_l_q;
	logic tog_l_q;
	logic tog_l_d;

	// Next toggle value
	always_comb
	begin
		tog_l_d = rst_l2_q ? 1'b0 : ~tog_l_q;
	end

	// Reset crossing and bit capture
	always_ff @(posedge link_scl)
	begin
		rst_l1_q <= rst;
		rst_l2_q <= rst_l1_q;
		bit_l_q  <= sda_i;
		tog_l_q  <= tog_l_d;
	end

	// ==========================================================
	// Synchronisers for pins and link toggle
	logic [mcp_pkg::SYNC_W-1:0] sync_in;
	logic [mcp_pkg::SYNC_W-1:0] s1_q;
	logic [mcp_pkg::SYNC_W-1:0] s2_q;
	logic sel_s, rstn_s, lp_s, fault_s, scl_s, sda_s, tog_s;

	assign sync_in = {tog_l_q, sda_i, link_scl, fault_in, low_power_request,
		module_reset_n, module_select_n};

	for (genvar i = 0; i < mcp_pkg::SYNC_W; i++)
	begin : g_sync
		// Two-stage synchroniser per input
		always_ff @(posedge clk)
		begin
			s1_q[i] <= sync_in[i];
			s2_q[i] <= s1_q[i];
		end
	end

	assign sel_s   = s2_q[0];
	assign rstn_s  = s2_q[1];
	assign lp_s    = s2_q[2];
	assign fault_s = s2_q[3];
	assign scl_s   = s2_q[4];
	assign sda_s   = s2_q[5];
	assign tog_s   = s2_q[6];

	// ==========================================================
	// Bus event detection
	logic scl_p_q, sda_p_q, tog_p_q;
	logic start_ev, stop_ev, scl_fall, bit_ev;

	// Previous synchronised levels
	always_ff @(posedge clk)
	begin
		scl_p_q <= rst ? 1'b1 : scl_s;
		sda_p_q <= rst ? 1'b1 : sda_s;
		tog_p_q <= tog_s;
	end

	// Start, stop, falling clock and new bit
	assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign scl_fall = scl_p_q & ~scl_s;
	assign bit_ev   = (tog_s ^ tog_p_q) & ~rst;

	// ==========================================================
	// Memory port
	mcp_mem_if #(.AW(mcp_pkg::MEM_AW), .DW(mcp_pkg::MEM_DW)) mbus ();

	mcp_mem #(
		.AW   (mcp_pkg::MEM_AW),
		.DW   (mcp_pkg::MEM_DW)
	) u_mem (
		.clk  (clk),
		.port (mbus)
	);

	// ==========================================================
	// Reset, status and flag state
	mcp_pkg::mcp_rs_t rs_q, rs_d;
	logic [CW-1:0] low_cnt_q, low_cnt_d;
	logic [7:0]    walk_q, walk_d;
	logic          pend_q, pend_d;
	logic          flag_rst_q, flag_rst_d;
	logic          flag_fault_q, flag_fault_d;
	logic          power_q, power_d;
	logic          hold, done_ev;
	logic          rd_flags, pw_wr, wr_stb;
	logic [7:0]    wr_byte;

	// Pulse timing, memory walk and sticky flags
	always_comb
	begin
		low_cnt_d = low_cnt_q;
		if (rstn_s)
			low_cnt_d = '0;
		else if (low_cnt_q != CW'(RESET_MIN_CYC))
			low_cnt_d = low_cnt_q + CW'(1);
		hold    = ~rstn_s & (low_cnt_q == CW'(RESET_MIN_CYC));
		rs_d    = rs_q;
		walk_d  = walk_q;
		done_ev = 1'b0;
		if (hold)
		begin
			rs_d   = mcp_pkg::MCP_RS_CLEAR;
			walk_d = '0;
		end
		else if (rs_q == mcp_pkg::MCP_RS_CLEAR)
		begin
			walk_d = walk_q + 8'h01;
			if (walk_q == mcp_pkg::WALK_LAST)
			begin
				rs_d    = mcp_pkg::MCP_RS_READY;
				done_ev = 1'b1;
			end
		end
		pend_d       = (rs_d == mcp_pkg::MCP_RS_CLEAR);
		flag_rst_d   = done_ev | (flag_rst_q & ~rd_flags);
		flag_fault_d = fault_s | (flag_fault_q & ~rd_flags);
		power_d      = power_q;
		if (pw_wr)
			power_d = wr_byte[mcp_pkg::POWER_LP_BIT];
		if (rs_d == mcp_pkg::MCP_RS_CLEAR)
		begin
			flag_rst_d   = 1'b0;
			flag_fault_d = 1'b0;
			power_d      = 1'b0;
		end
	end

	// Register reset and status state; power-up enters the walk
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rs_q         <= mcp_pkg::MCP_RS_CLEAR;
			low_cnt_q    <= '0;
			walk_q       <= '0;
			pend_q       <= 1'b1;
			flag_rst_q   <= 1'b0;
			flag_fault_q <= 1'b0;
			power_q      <= 1'b0;
		end
		else
		begin
			rs_q         <= rs_d;
			low_cnt_q    <= low_cnt_d;
			walk_q       <= walk_d;
			pend_q       <= pend_d;
			flag_rst_q   <= flag_rst_d;
			flag_fault_q <= flag_fault_d;
			power_q      <= power_d;
		end
	end

	// ==========================================================
	// Serial bus slave
	mcp_pkg::mcp_tw_t tw_q, tw_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic [7:0] ptr_q, ptr_d;
	logic       ackok_q, ackok_d;
	logic       drv_q, drv_d;
	logic [7:0] rd_byte;

	// Read data for the current pointer, live status bytes overlaid
	always_comb
	begin
		rd_byte = mbus.rdata;
		if (ptr_q == mcp_pkg::OFS_STATUS)
			rd_byte = 8'(pend_q) << mcp_pkg::STATUS_PEND_BIT;
		else if (ptr_q == mcp_pkg::OFS_FLAGS)
			rd_byte = (8'(flag_rst_q) << mcp_pkg::FLAG_RESET_BIT) |
				(8'(flag_fault_q) << mcp_pkg::FLAG_FAULT_BIT);
	end

	// Byte framing, acknowledge and pointer handling
	always_comb
	begin
		tw_d     = tw_q;
		cnt_d    = cnt_q;
		sh_d     = sh_q;
		tx_d     = tx_q;
		ptr_d    = ptr_q;
		ackok_d  = ackok_q;
		drv_d    = drv_q;
		wr_stb   = 1'b0;
		pw_wr    = 1'b0;
		rd_flags = 1'b0;
		wr_byte  = {sh_q[6:0], bit_l_q};
		if (rs_q == mcp_pkg::MCP_RS_CLEAR || sel_s)
		begin
			tw_d  = mcp_pkg::MCP_TW_IDLE;
			drv_d = 1'b0;
		end
		else if (start_ev)
		begin
			tw_d  = mcp_pkg::MCP_TW_ADDR;
			cnt_d = '0;
			drv_d = 1'b0;
		end
		else if (stop_ev)
		begin
			tw_d  = mcp_pkg::MCP_TW_IDLE;
			drv_d = 1'b0;
		end
		else if (bit_ev && tw_q != mcp_pkg::MCP_TW_IDLE)
		begin
			if (cnt_q != mcp_pkg::BITS_PER_BYTE)
			begin
				sh_d  = wr_byte;
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == mcp_pkg::LAST_DATA_BIT)
				begin
					case (tw_q)
						mcp_pkg::MCP_TW_ADDR: ackok_d = (wr_byte[7:1] == DEV_ADDR);
						mcp_pkg::MCP_TW_WRA:
						begin
							ptr_d   = wr_byte;
							ackok_d = 1'b1;
						end
						mcp_pkg::MCP_TW_WR:
						begin
							wr_stb  = 1'b1;
							pw_wr   = (ptr_q == mcp_pkg::OFS_POWER);
							ptr_d   = ptr_q + 8'h01;
							ackok_d = 1'b1;
						end
						mcp_pkg::MCP_TW_RD:
						begin
							ptr_d   = ptr_q + 8'h01;
							ackok_d = 1'b0;
						end
						default: ackok_d = 1'b0;
					endcase
				end
			end
			else
			begin
				cnt_d   = '0;
				ackok_d = 1'b0;
				case (tw_q)
					mcp_pkg::MCP_TW_ADDR:
					begin
						if (!ackok_q)
							tw_d = mcp_pkg::MCP_TW_IDLE;
						else if (sh_q[0])
						begin
							tw_d     = mcp_pkg::MCP_TW_RD;
							tx_d     = rd_byte;
							rd_flags = (ptr_q == mcp_pkg::OFS_FLAGS);
						end
						else
							tw_d = mcp_pkg::MCP_TW_WRA;
					end
					mcp_pkg::MCP_TW_WRA: tw_d = mcp_pkg::MCP_TW_WR;
					mcp_pkg::MCP_TW_WR:  tw_d = mcp_pkg::MCP_TW_WR;
					mcp_pkg::MCP_TW_RD:
					begin
						if (bit_l_q)
							tw_d = mcp_pkg::MCP_TW_IDLE;
						else
						begin
							tx_d     = rd_byte;
							rd_flags = (ptr_q == mcp_pkg::OFS_FLAGS);
						end
					end
					default: tw_d = mcp_pkg::MCP_TW_IDLE;
				endcase
			end
		end
		else if (scl_fall && tw_q != mcp_pkg::MCP_TW_IDLE)
		begin
			drv_d = (cnt_q == mcp_pkg::BITS_PER_BYTE && ackok_q) ||
				(tw_q == mcp_pkg::MCP_TW_RD && cnt_q != mcp_pkg::BITS_PER_BYTE &&
				!tx_q[~cnt_q[2:0]]);
		end
	end

	// Register serial state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tw_q    <= mcp_pkg::MCP_TW_IDLE;
			cnt_q   <= '0;
			sh_q    <= '0;
			tx_q    <= '0;
			ptr_q   <= '0;
			ackok_q <= 1'b0;
			drv_q   <= 1'b0;
		end
		else
		begin
			tw_q    <= tw_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			ptr_q   <= ptr_d;
			ackok_q <= ackok_d;
			drv_q   <= drv_d;
		end
	end

	// Memory access: walk writes defaults, otherwise the bus pointer
	assign mbus.we    = (rs_q == mcp_pkg::MCP_RS_CLEAR) | wr_stb;
	assign mbus.addr  = (rs_q == mcp_pkg::MCP_RS_CLEAR) ? walk_q : ptr_q;
	assign mbus.wdata = (rs_q == mcp_pkg::MCP_RS_CLEAR) ? mcp_pkg::RESET_BYTE : wr_byte;

	// ==========================================================
	// Output registers
	always_ff @(posedge clk)
	begin
		sda_o               <= 1'b0;
		interrupt_o         <= 1'b0;
		module_present_o    <= 1'b0;
		module_present_oe_n <= 1'b0;
		if (rst)
		begin
			sda_oe_n       <= 1'b1;
			interrupt_oe_n <= 1'b1;
			power_limit    <= 1'b0;
			reset_busy     <= 1'b1;
		end
		else
		begin
			sda_oe_n       <= ~drv_d;
			interrupt_oe_n <= ~(flag_rst_d | flag_fault_d);
			power_limit    <= lp_s | power_d;
			reset_busy     <= (rs_d == mcp_pkg::MCP_RS_CLEAR);
		end
	end

	// ==========================================================
	// Checks
	AST_DESELECT_IGNORES: assert property (@(posedge clk) disable iff (rst)
		(sel_s && start_ev) |=> (tw_q == mcp_pkg::MCP_TW_IDLE && sda_oe_n))
		else $error("Start answered while deselected");
	AST_MIN_PULSE: assert property (@(posedge clk) disable iff (rst)
		(rs_q == mcp_pkg::MCP_RS_CLEAR && $past(rs_q) == mcp_pkg::MCP_RS_READY)
		|-> ($past(low_cnt_q) == CW'(RESET_MIN_CYC) && !$past(rstn_s)))
		else $error("Reset began before the minimum low time");
	AST_WALK_DEFAULTS: assert property (@(posedge clk) disable iff (rst)
		(rs_q == mcp_pkg::MCP_RS_CLEAR) |-> (mbus.we && mbus.wdata == mcp_pkg::RESET_BYTE))
		else $error("Reset walk did not write defaults");
	AST_DONE_POSTS: assert property (@(posedge clk) disable iff (rst)
		(rs_q == mcp_pkg::MCP_RS_CLEAR && walk_q == mcp_pkg::WALK_LAST && !hold)
		|=> (!pend_q && flag_rst_q && !interrupt_oe_n))
		else $error("Reset end did not clear pending and raise interrupt");
	AST_POWERUP_INT: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> ##[256:300] !interrupt_oe_n)
		else $error("No completion interrupt after power-up");
	AST_LOW_POWER: assert property (@(posedge clk) disable iff (rst)
		lp_s |=> power_limit)
		else $error("Low power request did not limit power");
	AST_PRESENT_LOW: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> (!module_present_oe_n && !module_present_o))
		else $error("Presence line not driven low");
	AST_FAULT_INT: assert property (@(posedge clk) disable iff (rst)
		(fault_s && rs_q == mcp_pkg::MCP_RS_READY && !hold) |=> !interrupt_oe_n)
		else $error("Fault did not pull interrupt low");
	AST_INT_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
		!interrupt_oe_n |-> !interrupt_o)
		else $error("Interrupt driven high");

endmodule : mcp_top

`default_nettype wire

// >>> verification/mcp_host_model.sv
// Host controller model: bit-level master on the two-wire management bus.
// Assumes the bench resolves the open-drain data line and feeds it back.
`timescale 1ns/1ns
`default_nettype none

module mcp_host_model (
	output var  logic scl,
	output var  logic sda_pull,
	input  wire logic sda_in
);
	// ==========================================================
	// Idle: clock stands high, data released to the pull-up
	initial
	begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	// Clock pulses with data released: they step the link-side reset
	// synchroniser in and out of reset; the clock ends standing high
	task automatic idle_clocks(input int n);
		repeat (n)
		begin
			#31 scl = 1'b0;
			#62 scl = 1'b1;
			#32;
		end
	endtask : idle_clocks

	// Start or repeated start: data falls while clock is high
	task automatic start();
		#31 sda_pull = 1'b0;
		#32 scl = 1'b1;
		#31 sda_pull = 1'b1;
		#31 scl = 1'b0;
	endtask : start

	// One bit: data set while clock is low, line sampled mid-high
	task automatic bit_xfer(input logic b, output logic r);
		#31 sda_pull = ~b;
		#32 scl = 1'b1;
		#31 r = sda_in;
		#31 scl = 1'b0;
	endtask : bit_xfer

	// Byte MSB first, then the acknowledge bit
	task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], q[i]);
		bit_xfer(ack_in, ack_out);
	endtask : byte_xfer

	// Stop: data rises while clock is high
	task automatic stop();
		#31 sda_pull = 1'b1;
		#32 scl = 1'b1;
		#31 sda_pull = 1'b0;
		#31;
	endtask : stop

endmodule : mcp_host_model

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the module control pin logic.
// Assumes the host model above; the bench resolves the open-drain data line.
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam logic [6:0] ADDR = mcp_pkg::DEV_ADDR_DEF;
	localparam int unsigned RMIN = 4;

	logic clk, rst, scl, host_pull, sel_n, rst_n, lpr, fault;
	logic sda_o, sda_oe_n, int_o, int_oe_n, prs_o, prs_oe_n, plim, busy;
	logic [7:0] rd_q;
	wire logic sda_line;
	int miscompares, n_compared;

	// ==========================================================
	// Clock and open-drain data line with board pull-up
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	assign sda_line = (host_pull == 1'b1 || (sda_oe_n == 1'b0 && sda_o == 1'b0)) ? 1'b0 : 1'b1;

	mcp_host_model i_mcp_host_model (.scl(scl), .sda_pull(host_pull), .sda_in(sda_line));

	mcp_top #(.DEV_ADDR(ADDR), .RESET_MIN_CYC(RMIN)) i_mcp_top (
		.clk(clk), .rst(rst), .link_scl(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .module_select_n(sel_n), .module_reset_n(rst_n),
		.low_power_request(lpr), .fault_in(fault), .interrupt_o(int_o),
		.interrupt_oe_n(int_oe_n), .module_present_o(prs_o),
		.module_present_oe_n(prs_oe_n), .power_limit(plim), .reset_busy(busy));

	// ==========================================================
	// Comparison, verdict and waits
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask : cycles

	// Bounded wait for the default walk to finish
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 400)
		begin
			miscompares++;
			summarize();
		end
	endtask : wait_idle

	// ==========================================================
	// Bus transfers: pointer write with data, pointer read
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic nack);
		logic [7:0] q;
		logic a;
		i_mcp_host_model.start();
		i_mcp_host_model.byte_xfer({ADDR, 1'b0}, 1'b1, q, a);
		check({7'h00, a}, {7'h00, nack});
		if (a == 1'b0)
		begin
			i_mcp_host_model.byte_xfer(ptr, 1'b1, q, a);
			i_mcp_host_model.byte_xfer(d, 1'b1, q, a);
			check({7'h00, a}, 8'h00);
		end
		i_mcp_host_model.stop();
		cycles(8);
	endtask : wr

	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		logic [7:0] q;
		logic a;
		i_mcp_host_model.start();
		i_mcp_host_model.byte_xfer({ADDR, 1'b0}, 1'b1, q, a);
		i_mcp_host_model.byte_xfer(ptr, 1'b1, q, a);
		i_mcp_host_model.start();
		i_mcp_host_model.byte_xfer({ADDR, 1'b1}, 1'b1, q, a);
		check({7'h00, a}, 8'h00);
		i_mcp_host_model.byte_xfer(8'hFF, 1'b1, d, a);
		i_mcp_host_model.stop();
		cycles(8);
	endtask : rd

	// ==========================================================
	// Main sequence
	initial
	begin
		miscompares = 0;
		n_compared = 0;
		rst = 1'b1;
		sel_n = 1'b0;
		rst_n = 1'b1;
		lpr = 1'b0;
		fault = 1'b0;
		fork
			cycles(16);
			i_mcp_host_model.idle_clocks(3);
		join
		cycles(1);
		rst = 1'b0;
		// Two more link clocks let the link side leave reset before any frame
		i_mcp_host_model.idle_clocks(2);
		// Power-up completion; status is read only after it
		wait_idle();
		cycles(4);
		check({7'h00, int_oe_n}, 8'h00);
		check({6'h00, prs_o, prs_oe_n}, 8'h00);
		check({7'h00, int_o}, 8'h00);
		rd(mcp_pkg::OFS_STATUS, rd_q);
		check({7'h00, rd_q[mcp_pkg::STATUS_PEND_BIT]}, 8'h00);
		rd(mcp_pkg::OFS_FLAGS, rd_q);
		check({6'h00, rd_q[1:0]}, 8'h01);
		check({7'h00, int_oe_n}, 8'h01);
		$display("test power_up done");
		// Memory writes and reads, then traffic while deselected
		wr(8'h10, 8'hA5, 1'b0);
		wr(8'hFF, 8'h3C, 1'b0);
		rd(8'h10, rd_q);
		check(rd_q, 8'hA5);
		rd(8'hFF, rd_q);
		check(rd_q, 8'h3C);
		sel_n = 1'b1;
		wr(8'h10, 8'h77, 1'b1);
		sel_n = 1'b0;
		rd(8'h10, rd_q);
		check(rd_q, 8'hA5);
		$display("test bus_access done");
		// Power limit from the pin and from the memory bit
		lpr = 1'b1;
		cycles(6);
		check({7'h00, plim}, 8'h01);
		lpr = 1'b0;
		cycles(6);
		check({7'h00, plim}, 8'h00);
		wr(mcp_pkg::OFS_POWER, 8'h01, 1'b0);
		check({7'h00, plim}, 8'h01);
		wr(mcp_pkg::OFS_POWER, 8'h00, 1'b0);
		check({7'h00, plim}, 8'h00);
		$display("test power_limit done");
		// Fault raises the interrupt until its flag is read
		fault = 1'b1;
		cycles(6);
		check({7'h00, int_oe_n}, 8'h00);
		fault = 1'b0;
		cycles(6);
		check({7'h00, int_oe_n}, 8'h00);
		rd(mcp_pkg::OFS_FLAGS, rd_q);
		check({6'h00, rd_q[1:0]}, 8'h02);
		check({7'h00, int_oe_n}, 8'h01);
		$display("test fault done");
		// Reset pin: a short glitch is ignored, a long pulse resets
		rst_n = 1'b0;
		cycles(RMIN - 2);
		rst_n = 1'b1;
		cycles(8);
		check({7'h00, busy}, 8'h00);
		rst_n = 1'b0;
		cycles(RMIN + 6);
		check({7'h00, busy}, 8'h01);
		rst_n = 1'b1;
		wait_idle();
		cycles(4);
		check({7'h00, int_oe_n}, 8'h00);
		rd(8'h10, rd_q);
		check(rd_q, 8'h00);
		rd(mcp_pkg::OFS_STATUS, rd_q);
		check({7'h00, rd_q[mcp_pkg::STATUS_PEND_BIT]}, 8'h00);
		rd(mcp_pkg::OFS_FLAGS, rd_q);
		check({6'h00, rd_q[1:0]}, 8'h01);
		$display("test reset_pin done");
		summarize();
	end

endmodule : testbench

`default_nettype wire
